// >>> rtl/rplo_lane_out.sv
// Function
// - Raw mode: lane A bit9 carries code bit 9
// - Decoded mode: lane A bit9 flags decode error
// - Lane A bit9 launched per lane A clock edge
// - Own-clock mode: lanes B-D buses on own clock
// - Common mode: lanes B-D buses on lane A clock
// - Lanes B-D bit8 follow bus clock selection
// - Raw mode: lanes B-D bit8 carry code bit 8
// - Decoded mode: lanes B-D bit8 flag control char
// - Decoded mode: lane A bit8 flags control char
`timescale 1ns/1ps
`default_nettype none
`include "rplo_regs.svh"

module rplo_lane_out
	import rplo_pkg::*;
(
	input  wire logic                   clk,
	input  wire logic                   rst_n,
	input  wire logic                   ce,
	input  wire logic                   decode_enable,
	input  wire logic                   common_clock_select,
	input  wire logic                   lane_a_rx_clock,
	input  wire logic                   lane_b_rx_clock,
	input  wire logic                   lane_c_rx_clock,
	input  wire logic                   lane_d_rx_clock,
	input  wire logic                   lane_a_in_valid,
	output wire logic                   lane_a_in_ready,
	input  wire logic [`RPLO_CODE_W-1:0] lane_a_in_code,
	input  wire logic [`RPLO_BYTE_W-1:0] lane_a_in_byte,
	input  wire logic                   lane_a_in_kchar,
	input  wire logic                   lane_a_in_err,
	input  wire logic                   lane_b_in_valid,
	output wire logic                   lane_b_in_ready,
	input  wire logic [`RPLO_CODE_W-1:0] lane_b_in_code,
	input  wire logic [`RPLO_BYTE_W-1:0] lane_b_in_byte,
	input  wire logic                   lane_b_in_kchar,
	input  wire logic                   lane_b_in_err,
	input  wire logic                   lane_c_in_valid,
	output wire logic                   lane_c_in_ready,
	input  wire logic [`RPLO_CODE_W-1:0] lane_c_in_code,
	input  wire logic [`RPLO_BYTE_W-1:0] lane_c_in_byte,
	input  wire logic                   lane_c_in_kchar,
	input  wire logic                   lane_c_in_err,
	input  wire logic                   lane_d_in_valid,
	output wire logic                   lane_d_in_ready,
	input  wire logic [`RPLO_CODE_W-1:0] lane_d_in_code,
	input  wire logic [`RPLO_BYTE_W-1:0] lane_d_in_byte,
	input  wire logic                   lane_d_in_kchar,
	input  wire logic                   lane_d_in_err,
	output wire logic [`RPLO_BYTE_W-1:0] lane_a_rx_bus,
	output wire logic                   lane_a_kflag_or_bit8,
	output wire logic                   lane_a_error_or_bit9,
	output wire logic [`RPLO_BYTE_W-1:0] lane_b_rx_bus,
	output wire logic                   lane_b_kflag_or_bit8,
	output wire logic                   lane_b_error_or_bit9,
	output wire logic [`RPLO_BYTE_W-1:0] lane_c_rx_bus,
	output wire logic                   lane_c_kflag_or_bit8,
	output wire logic                   lane_c_error_or_bit9,
	output wire logic [`RPLO_BYTE_W-1:0] lane_d_rx_bus,
	output wire logic                   lane_d_kflag_or_bit8,
	output wire logic                   lane_d_error_or_bit9
);
	// Builds the word presented on one lane for the selected mode
	function automatic rplo_word_type lane_word(
		input rplo_mode_type mode,
		input rplo_word_type code,
		input rplo_byte_type dbyte,
		input logic          kchar,
		input logic          err
	);
		rplo_word_type w;
		w = code;
		if (mode == RPLO_MODE_DECODED) begin
			w = {err, kchar, dbyte};
		end
		return w;
	endfunction

	logic [`RPLO_PIN_W-1:0] pin_sync1_r;
	logic [`RPLO_PIN_W-1:0] pin_sync2_r;
	logic [`RPLO_LANES-1:0] clk_hist_r;
	logic [`RPLO_LANES-1:0] edge_w;
	logic [`RPLO_LANES-1:0] launch_w;
	logic [`RPLO_LANES-1:0] in_valid_w;
	logic [`RPLO_LANES-1:0] in_ready_w;
	logic [`RPLO_LANES-1:0] in_kchar_w;
	logic [`RPLO_LANES-1:0] in_err_w;
	logic [`RPLO_LANES-1:0] fifo_valid_w;
	rplo_word_type          in_code_w  [`RPLO_LANES];
	rplo_byte_type          in_byte_w  [`RPLO_LANES];
	rplo_word_type          push_word_w[`RPLO_LANES];
	rplo_word_type          fifo_data_w[`RPLO_LANES];
	rplo_word_type          out_word_r [`RPLO_LANES];
	rplo_mode_type          mode_w;
	rplo_clksrc_type        clksrc_w;

	assign in_valid_w = {lane_d_in_valid, lane_c_in_valid,
	                     lane_b_in_valid, lane_a_in_valid};
	assign in_kchar_w = {lane_d_in_kchar, lane_c_in_kchar,
	                     lane_b_in_kchar, lane_a_in_kchar};
	assign in_err_w   = {lane_d_in_err, lane_c_in_err,
	                     lane_b_in_err, lane_a_in_err};
	assign in_code_w[`RPLO_LANE_A] = lane_a_in_code;
	assign in_code_w[`RPLO_LANE_B] = lane_b_in_code;
	assign in_code_w[`RPLO_LANE_C] = lane_c_in_code;
	assign in_code_w[`RPLO_LANE_D] = lane_d_in_code;
	assign in_byte_w[`RPLO_LANE_A] = lane_a_in_byte;
	assign in_byte_w[`RPLO_LANE_B] = lane_b_in_byte;
	assign in_byte_w[`RPLO_LANE_C] = lane_c_in_byte;
	assign in_byte_w[`RPLO_LANE_D] = lane_d_in_byte;

	// Lane clocks and config pins come from outside this clock domain
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_sync1_r <= `RPLO_PIN_RST;
			pin_sync2_r <= `RPLO_PIN_RST;
			clk_hist_r  <= `RPLO_CLK_RST;
		end else if (ce) begin
			pin_sync1_r <= {common_clock_select, decode_enable,
			                lane_d_rx_clock, lane_c_rx_clock,
			                lane_b_rx_clock, lane_a_rx_clock};
			pin_sync2_r <= pin_sync1_r;
			clk_hist_r  <= pin_sync2_r[`RPLO_LANES-1:0];
		end
	end

	assign mode_w   = rplo_mode_type'(pin_sync2_r[`RPLO_PIN_DEC]);
	assign clksrc_w = rplo_clksrc_type'(pin_sync2_r[`RPLO_PIN_SEL]);
	// Both rising and falling edges of each lane clock
	assign edge_w   = pin_sync2_r[`RPLO_LANES-1:0] ^ clk_hist_r;

	genvar gi;
	generate
		for (gi = 0; gi < `RPLO_LANES; gi++) begin : g_lane
			wire sel_edge_w = (clksrc_w == RPLO_CLK_LANE_A) ?
			                  edge_w[`RPLO_LANE_A] : edge_w[gi];
			assign launch_w[gi] = ce & sel_edge_w;
			// Flags and byte share one word
			assign push_word_w[gi] = lane_word(mode_w, in_code_w[gi],
			                         in_byte_w[gi], in_kchar_w[gi],
			                         in_err_w[gi]);

			rplo_fifo #(
				.WIDTH (`RPLO_CODE_W),
				.DEPTH (`RPLO_FIFO_DEPTH)
			) u_fifo (
				.clk       (clk),
				.rst_n     (rst_n),
				.ce        (ce),
				.in_valid  (in_valid_w[gi]),
				.in_ready  (in_ready_w[gi]),
				.in_data   (push_word_w[gi]),
				.out_valid (fifo_valid_w[gi]),
				.out_ready (launch_w[gi]),
				.out_data  (fifo_data_w[gi])
			);

			// Whole word launched at once; held when the buffer is dry
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					out_word_r[gi] <= `RPLO_WORD_RST;
				end else if (launch_w[gi] && fifo_valid_w[gi]) begin
					out_word_r[gi] <= fifo_data_w[gi];
				end
			end
		end
	endgenerate

	assign lane_a_in_ready = in_ready_w[`RPLO_LANE_A];
	assign lane_b_in_ready = in_ready_w[`RPLO_LANE_B];
	assign lane_c_in_ready = in_ready_w[`RPLO_LANE_C];
	assign lane_d_in_ready = in_ready_w[`RPLO_LANE_D];
	assign lane_a_rx_bus        = out_word_r[`RPLO_LANE_A][`RPLO_BYTE_W-1:0];
	assign lane_a_kflag_or_bit8 = out_word_r[`RPLO_LANE_A][`RPLO_KBIT];
	assign lane_a_error_or_bit9 = out_word_r[`RPLO_LANE_A][`RPLO_EBIT];
	assign lane_b_rx_bus        = out_word_r[`RPLO_LANE_B][`RPLO_BYTE_W-1:0];
	assign lane_b_kflag_or_bit8 = out_word_r[`RPLO_LANE_B][`RPLO_KBIT];
	assign lane_b_error_or_bit9 = out_word_r[`RPLO_LANE_B][`RPLO_EBIT];
	assign lane_c_rx_bus        = out_word_r[`RPLO_LANE_C][`RPLO_BYTE_W-1:0];
	assign lane_c_kflag_or_bit8 = out_word_r[`RPLO_LANE_C][`RPLO_KBIT];
	assign lane_c_error_or_bit9 = out_word_r[`RPLO_LANE_C][`RPLO_EBIT];
	assign lane_d_rx_bus        = out_word_r[`RPLO_LANE_D][`RPLO_BYTE_W-1:0];
	assign lane_d_kflag_or_bit8 = out_word_r[`RPLO_LANE_D][`RPLO_KBIT];
	assign lane_d_error_or_bit9 = out_word_r[`RPLO_LANE_D][`RPLO_EBIT];

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	wire fire_a_w = ce & lane_a_in_valid & lane_a_in_ready;
	wire fire_b_w = ce & lane_b_in_valid & lane_b_in_ready;
	wire pop_a_w  = launch_w[`RPLO_LANE_A] & fifo_valid_w[`RPLO_LANE_A];
	wire pop_b_w  = launch_w[`RPLO_LANE_B] & fifo_valid_w[`RPLO_LANE_B];

	sequence s_pop_a;
		pop_a_w;
	endsequence
	sequence s_lane_b_own_edge;
		clksrc_w == RPLO_CLK_OWN && edge_w[`RPLO_LANE_B] && ce &&
		fifo_valid_w[`RPLO_LANE_B];
	endsequence
	sequence s_lane_b_a_edge;
		clksrc_w == RPLO_CLK_LANE_A && edge_w[`RPLO_LANE_A] && ce &&
		fifo_valid_w[`RPLO_LANE_B];
	endsequence

	property p_raw_bit9;
		fire_a_w && mode_w == RPLO_MODE_RAW |->
			push_word_w[`RPLO_LANE_A][`RPLO_EBIT] ==
			lane_a_in_code[`RPLO_EBIT];
	endproperty
	a_raw_bit9: assert property (p_raw_bit9) else $error("raw bit9 lost");

	property p_err_flag;
		fire_a_w && mode_w == RPLO_MODE_DECODED |->
			push_word_w[`RPLO_LANE_A][`RPLO_EBIT] == lane_a_in_err;
	endproperty
	a_err_flag: assert property (p_err_flag) else $error("error flag");

	property p_lane_a_launch;
		s_pop_a |=> (lane_a_error_or_bit9 ==
			$past(fifo_data_w[`RPLO_LANE_A][`RPLO_EBIT])) and
			(!pop_a_w |=> $stable(lane_a_error_or_bit9));
	endproperty
	a_lane_a_launch: assert property (p_lane_a_launch)
		else $error("a launch");

	property p_b_own_clock;
		s_lane_b_own_edge |=> lane_b_rx_bus ==
			$past(fifo_data_w[`RPLO_LANE_B][`RPLO_BYTE_W-1:0]);
	endproperty
	a_b_own_clock: assert property (p_b_own_clock) else $error("b own");

	property p_b_a_clock;
		s_lane_b_a_edge |=> lane_b_rx_bus ==
			$past(fifo_data_w[`RPLO_LANE_B][`RPLO_BYTE_W-1:0]);
	endproperty
	a_b_a_clock: assert property (p_b_a_clock) else $error("b on a clk");

	property p_b_bit8_hold;
		!pop_b_w |=> $stable(lane_b_kflag_or_bit8) && $stable(lane_b_rx_bus);
	endproperty
	a_b_bit8_hold: assert property (p_b_bit8_hold) else $error("b hold");

	property p_raw_bit8;
		fire_b_w && mode_w == RPLO_MODE_RAW |->
			push_word_w[`RPLO_LANE_B][`RPLO_KBIT] ==
			lane_b_in_code[`RPLO_KBIT];
	endproperty
	a_raw_bit8: assert property (p_raw_bit8) else $error("raw bit8");

	property p_b_kflag;
		fire_b_w && mode_w == RPLO_MODE_DECODED |->
			push_word_w[`RPLO_LANE_B][`RPLO_KBIT] == lane_b_in_kchar;
	endproperty
	a_b_kflag: assert property (p_b_kflag) else $error("b kflag");

	property p_a_kflag;
		fire_a_w && mode_w == RPLO_MODE_DECODED |->
			push_word_w[`RPLO_LANE_A][`RPLO_KBIT] == lane_a_in_kchar;
	endproperty
	a_a_kflag: assert property (p_a_kflag) else $error("a kflag");

	property p_aligned;
		s_pop_a |=> {lane_a_error_or_bit9, lane_a_kflag_or_bit8,
			lane_a_rx_bus} == $past(fifo_data_w[`RPLO_LANE_A]);
	endproperty
	a_aligned: assert property (p_aligned) else $error("flags misaligned");
endmodule

`default_nettype wire

// >>> rtl/rplo_regs.svh
`ifndef RPLO_REGS_SVH
`define RPLO_REGS_SVH

// Lane count and lane indices
`define RPLO_LANES      4
`define RPLO_LANE_A     0
`define RPLO_LANE_B     1
`define RPLO_LANE_C     2
`define RPLO_LANE_D     3

// Word layout on each lane output
`define RPLO_CODE_W     10
`define RPLO_BYTE_W     8
`define RPLO_KBIT       8
`define RPLO_EBIT       9

// Buffering and synchroniser sizes
`define RPLO_FIFO_DEPTH 8
`define RPLO_PIN_W      6
`define RPLO_PIN_DEC    4
`define RPLO_PIN_SEL    5

// Reset values
`define RPLO_WORD_RST   10'h000
`define RPLO_PIN_RST    6'h00
`define RPLO_CLK_RST    4'h0

`endif

// >>> rtl/rplo_pkg.sv
`default_nettype none
`include "rplo_regs.svh"

package rplo_pkg;

	typedef logic [`RPLO_CODE_W-1:0] rplo_word_type;
	typedef logic [`RPLO_BYTE_W-1:0] rplo_byte_type;

	typedef enum logic {
		RPLO_MODE_RAW     = 1'b0,
		RPLO_MODE_DECODED = 1'b1
	} rplo_mode_type;

	typedef enum logic {
		RPLO_CLK_OWN    = 1'b0,
		RPLO_CLK_LANE_A = 1'b1
	} rplo_clksrc_type;

endpackage

`default_nettype wire

// >>> rtl/rplo_fifo.sv
`timescale 1ns/1ps
`default_nettype none
`include "rplo_regs.svh"

module rplo_fifo #(
	parameter int WIDTH = `RPLO_CODE_W,
	parameter int DEPTH = `RPLO_FIFO_DEPTH
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             ce,
	input  wire logic             in_valid,
	output var  logic             in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output var  logic             out_valid,
	input  wire logic             out_ready,
	output wire logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_r;
	logic [AW-1:0]    rd_ptr_r;
	logic [AW:0]      count_r;
	logic [AW:0]      count_nxt;
	wire              push_w = ce & in_valid & in_ready;
	wire              pop_w  = ce & out_valid & out_ready;

	assign count_nxt = count_r + (AW+1)'(push_w) - (AW+1)'(pop_w);
	assign out_data  = mem[rd_ptr_r];

	always_ff @(posedge clk) begin
		if (push_w) begin
			mem[wr_ptr_r] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_r  <= '0;
			rd_ptr_r  <= '0;
			count_r   <= '0;
			in_ready  <= 1'b1;
			out_valid <= 1'b0;
		end else if (ce) begin
			wr_ptr_r  <= push_w ? wr_ptr_r + 1'b1 : wr_ptr_r;
			rd_ptr_r  <= pop_w ? rd_ptr_r + 1'b1 : rd_ptr_r;
			count_r   <= count_nxt;
			in_ready  <= count_nxt != FULL_CNT;
			out_valid <= count_nxt != '0;
		end
	end
endmodule

`default_nettype wire

// >>> verification/rplo_rx_model.sv
`timescale 1ns/1ps
`default_nettype none

module rplo_rx_model (
	input  wire logic        common_clock_select,
	input  wire logic [3:0]  lane_clk,
	input  wire logic [39:0] words,
	output var  logic [39:0] cap
);
	wire logic [3:0] sel_clk;

	// Lane A always uses its own clock
	assign sel_clk = common_clock_select ? {4{lane_clk[0]}} : lane_clk;

	initial cap = '0;

	for (genvar i = 0; i < 4; i++) begin : g_lane
		always @(posedge sel_clk[i] or negedge sel_clk[i]) begin
			cap[i*10+:10] <= words[i*10+:10];
		end
	end
endmodule

`default_nettype wire

// >>> verification/rplo_lane_out_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module rplo_lane_out_tb_top
	import rplo_pkg::*;
;
	typedef struct packed {
		logic          m;
		logic          s;
		rplo_word_type c;
		rplo_byte_type b;
		logic          k;
		logic          e;
	} rplo_row_type;

	logic            clk;
	logic            rst_n;
	logic            mode;
	logic            csel;
	logic [3:0]      lclk;
	logic            tick;
	logic [3:0]      vld;
	logic [3:0]      kc;
	logic [3:0]      er;
	wire logic [3:0] rdy;
	wire logic [3:0] kf;
	wire logic [3:0] eb;
	wire logic [39:0] words;
	wire logic [39:0] cap;
	rplo_word_type   code [4];
	rplo_byte_type   byt [4];
	rplo_byte_type   bus [4];
	rplo_word_type   prev [4];
	rplo_row_type    r;
	int              miscompares;
	int              n_tests;
	rplo_row_type    rows [5] = '{
		'{1'h0, 1'h0, 10'h2b5, 8'h00, 1'h0, 1'h0},
		'{1'h0, 1'h1, 10'h14a, 8'h00, 1'h0, 1'h0},
		'{1'h1, 1'h0, 10'h000, 8'hbc, 1'h1, 1'h0},
		'{1'h1, 1'h1, 10'h3ff, 8'h5a, 1'h0, 1'h1},
		'{1'h1, 1'h0, 10'h155, 8'hf7, 1'h1, 1'h1}
	};

	for (genvar i = 0; i < 4; i++) begin : g_w
		assign words[i*10+:10] = {eb[i], kf[i], bus[i]};
	end

	rplo_lane_out DUT (
		.clk(clk), .rst_n(rst_n), .ce(1'h1), .decode_enable(mode),
		.common_clock_select(csel),
		.lane_a_rx_clock(lclk[0]), .lane_b_rx_clock(lclk[1]),
		.lane_c_rx_clock(lclk[2]), .lane_d_rx_clock(lclk[3]),
		.lane_a_in_valid(vld[0]), .lane_a_in_ready(rdy[0]),
		.lane_a_in_code(code[0]), .lane_a_in_byte(byt[0]),
		.lane_a_in_kchar(kc[0]), .lane_a_in_err(er[0]),
		.lane_b_in_valid(vld[1]), .lane_b_in_ready(rdy[1]),
		.lane_b_in_code(code[1]), .lane_b_in_byte(byt[1]),
		.lane_b_in_kchar(kc[1]), .lane_b_in_err(er[1]),
		.lane_c_in_valid(vld[2]), .lane_c_in_ready(rdy[2]),
		.lane_c_in_code(code[2]), .lane_c_in_byte(byt[2]),
		.lane_c_in_kchar(kc[2]), .lane_c_in_err(er[2]),
		.lane_d_in_valid(vld[3]), .lane_d_in_ready(rdy[3]),
		.lane_d_in_code(code[3]), .lane_d_in_byte(byt[3]),
		.lane_d_in_kchar(kc[3]), .lane_d_in_err(er[3]),
		.lane_a_rx_bus(bus[0]), .lane_a_kflag_or_bit8(kf[0]),
		.lane_a_error_or_bit9(eb[0]),
		.lane_b_rx_bus(bus[1]), .lane_b_kflag_or_bit8(kf[1]),
		.lane_b_error_or_bit9(eb[1]),
		.lane_c_rx_bus(bus[2]), .lane_c_kflag_or_bit8(kf[2]),
		.lane_c_error_or_bit9(eb[2]),
		.lane_d_rx_bus(bus[3]), .lane_d_kflag_or_bit8(kf[3]),
		.lane_d_error_or_bit9(eb[3])
	);

	rplo_rx_model u_rx (
		.common_clock_select(csel),
		.lane_clk(lclk),
		.words(words),
		.cap(cap)
	);

	always #4 clk = ~clk;

	// Lane clock edges sit on a 62.5 ns grid that never meets a clk edge
	initial begin
		tick = 0;
		#0.25;
		forever #62.5 tick = ~tick;
	end

	function automatic rplo_word_type expw(rplo_row_type x, int i);
		return x.m ? {x.e, x.k, x.b ^ 8'(i)} : x.c ^ 10'(i);
	endfunction

	task summarize;
		$display("checks %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task chk(input string nm, input rplo_word_type e, input rplo_word_type s);
		n_tests++;
		if (s !== e) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask

	// Lanes in upd expect the new word, the others hold
	task chk_all(input rplo_row_type x, input logic [3:0] upd);
		for (int i = 0; i < 4; i++) begin
			if (upd[i])
				prev[i] = expw(x, i);
			chk($sformatf("lane %0d word", i), prev[i], words[i*10+:10]);
		end
	endtask

	task setup(input rplo_row_type x);
		@(negedge clk);
		mode = x.m;
		csel = x.s;
		repeat (4) @(negedge clk);
	endtask

	task push(input rplo_row_type x);
		@(negedge clk);
		for (int i = 0; i < 4; i++) begin
			code[i] = x.c ^ 10'(i);
			byt[i] = x.b ^ 8'(i);
		end
		kc = {4{x.k}};
		er = {4{x.e}};
		vld = 4'hf;
		while (rdy !== 4'hf) @(negedge clk);
		@(negedge clk);
		vld = 4'h0;
	endtask

	// One lane clock edge per call; back to back calls give edges 62.5 ns apart
	task launch(input logic [3:0] w);
		@(tick);
		lclk = lclk ^ w;
		#60;
	endtask

	initial begin
		{clk, rst_n, mode, csel, lclk, vld, kc, er} = '0;
		for (int i = 0; i < 4; i++) begin
			code[i] = '0;
			byt[i] = '0;
			prev[i] = '0;
		end
		repeat (6) @(posedge clk);
		chk("ready in reset", 10'(rdy), 10'h00f);
		chk_all(rows[0], 4'h0);
		@(negedge clk);
		rst_n = 1;
		repeat (3) @(negedge clk);
		$display("test reset done");
		foreach (rows[n]) begin
			setup(rows[n]);
			push(rows[n]);
			launch(rows[n].s ? 4'h1 : 4'hf);
			for (int i = 0; i < 4; i++)
				chk("capture", prev[i], cap[i*10+:10]);
			chk_all(rows[n], 4'hf);
		end
		$display("test table done");
		setup(rows[1]);
		push(rows[1]);
		launch(4'he);
		chk_all(rows[1], 4'h0);
		launch(4'h1);
		chk_all(rows[1], 4'hf);
		setup(rows[2]);
		push(rows[2]);
		launch(4'h1);
		chk_all(rows[2], 4'h1);
		launch(4'he);
		chk_all(rows[2], 4'hf);
		$display("test clock select done");
		setup(rows[0]);
		r = rows[0];
		for (int n = 0; n < 8; n++) begin
			r.c = 10'(n * 37);
			push(r);
		end
		repeat (2) @(negedge clk);
		chk("ready when full", 10'(rdy), 10'h000);
		for (int n = 0; n < 8; n++) begin
			r.c = 10'(n * 37);
			launch(4'hf);
			chk_all(r, 4'hf);
		end
		launch(4'hf);
		chk_all(r, 4'h0);
		chk("ready when empty", 10'(rdy), 10'h00f);
		$display("test fifo done");
		summarize;
	end

	initial begin
		#50000;
		miscompares++;
		summarize;
	end
endmodule

`default_nettype wire
